// ---- core/dhic_pkg.sv ----
package dhic_pkg;

   // Channel space: thirty-two output channels plus the offset channel.
   localparam int          CHANS        = 32;
   localparam int          ADDR_W       = 5;
   localparam int          CODE_W       = 14;
   localparam int          CH_IDX_W     = 6;
   localparam logic [5:0]  OFFSET_CHAN  = 6'h20;
   localparam logic [32:0] MASK_ALL_OUT = 33'h0FFFFFFFF;
   localparam logic [32:0] MASK_ONE     = 33'h000000001;

   // Serial frame length in shift-clock bits.
   localparam int          FRAME_BITS   = 21;
   localparam int          FRAME_CNT_W  = 5;

   // System clock and the track/reset pulse window.
   localparam int          CLK_PERIOD_PS = 100000;
   localparam int          RST_MIN_NS    = 90;
   localparam int          RST_MAX_NS    = 200;
   localparam int          RST_MIN_RAW   = (RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int          RST_MAX_RAW   = (RST_MAX_NS * 1000) / CLK_PERIOD_PS;
   localparam int          TRK_CNT_W     = 4;
   localparam logic [3:0]  TRK_MIN_CYC   = 4'((RST_MIN_RAW < 1) ? 1 : RST_MIN_RAW);
   localparam logic [3:0]  TRK_MAX_CYC   = 4'((RST_MAX_RAW < 1) ? 1 : RST_MAX_RAW);
   localparam logic [3:0]  TRK_CNT_SAT   = 4'hF;

   // Acquisition length in system clocks.
   localparam int          ACQ_CYC_DEFAULT = 16;
   localparam int          ACQ_CNT_W       = 16;

   typedef enum logic [1:0] {
      DHIC_IDLE,
      DHIC_TRACK,
      DHIC_ACQ
   } dhic_state_t;

   // Serial frame as it arrives, first bit at the top.
   typedef struct packed {
      logic              rd;
      logic              offs;
      logic [4:0]        addr;
      logic [13:0]       code;
   } dhic_frame_t;

   // Control pins as seen by the system-clock logic.
   typedef struct packed {
      logic              hold;
      logic              pick;
      logic              cs_n;
      logic              wr_n;
      logic              offs;
      logic              cal;
      logic              trk;
      logic [4:0]        addr;
   } dhic_pins_t;

   typedef logic [32:0][13:0] dhic_bank_t;

   // Pin image held by the synchronisers during reset.
   localparam dhic_pins_t PINS_IDLE = '{hold: 1'b0, pick: 1'b0, cs_n: 1'b1, wr_n: 1'b1,
                                        offs: 1'b0, cal: 1'b0, trk: 1'b1, addr: 5'h1F};

endpackage

// ---- core/dhic_serial_link.sv ----
`timescale 1ns/1ps
module dhic_serial_link (
   input  wire logic                 i_reset,
   input  wire logic                 i_sclk,
   input  wire logic                 i_sync_n,
   input  wire logic                 i_din,
   input  wire logic [13:0]          i_rb_code,
   output logic                      o_dout,
   output dhic_pkg::dhic_frame_t     o_frame,
   output logic                      o_frame_tog
);

   typedef struct packed {
      logic [4:0]                    cnt;
      logic [19:0]                   sh;
   } dhic_rx_t;

   typedef struct packed {
      dhic_pkg::dhic_frame_t         word;
      logic                          tog;
   } dhic_hold_t;

   dhic_rx_t    rx_r;
   dhic_rx_t    rx_nxt;
   dhic_hold_t  hold_r;
   dhic_hold_t  hold_nxt;
   logic [13:0] tx_r;
   logic        frame_rst;
   logic        last_bit;

   // An idle frame pin holds the receiver cleared, so stray clocks are ignored.
   assign frame_rst = i_reset | i_sync_n;
   assign last_bit  = (rx_r.cnt == 5'(dhic_pkg::FRAME_BITS - 1));

   always_comb begin
      rx_nxt   = rx_r;
      hold_nxt = hold_r;
      rx_nxt.sh  = {rx_r.sh[18:0], i_din};
      rx_nxt.cnt = last_bit ? 5'h00 : rx_r.cnt + 5'h01;
      if (last_bit) begin
         hold_nxt.word = dhic_pkg::dhic_frame_t'({rx_r.sh, i_din});
         hold_nxt.tog  = ~hold_r.tog;
      end
   end

   // Input bits are taken on the falling shift-clock edge.
   always_ff @(negedge i_sclk or posedge frame_rst) begin
      if (frame_rst) begin
         rx_r <= '0;
      end else begin
         rx_r <= rx_nxt;
      end
   end

   always_ff @(negedge i_sclk or posedge i_reset) begin
      if (i_reset) begin
         hold_r <= '0;
      end else begin
         hold_r <= hold_nxt;
      end
   end

   // Readback bits leave on the rising edge, ready for the next falling edge.
   always_ff @(posedge i_sclk or posedge i_reset) begin
      if (i_reset) begin
         tx_r <= '0;
      end else if (rx_r.cnt == 5'h00) begin
         tx_r <= i_rb_code;
      end else begin
         tx_r <= {tx_r[12:0], 1'b0};
      end
   end

   assign o_dout      = tx_r[13];
   assign o_frame     = hold_r.word;
   assign o_frame_tog = hold_r.tog;

   chk_rb_shift_order: assert property (@(posedge i_sclk) disable iff (frame_rst)
      rx_r.cnt != 5'h00 |=> o_dout == $past(tx_r[12]))
      else $error("Readback bit order broken.");

endmodule

// ---- core/dhic_host_ctrl.sv ----
`timescale 1ns/1ps
// Summary of operation
// - A parallel access picks one of 32 channels with five address lines, top line most significant.
// - An address line that nobody drives reads as one.
// - In parallel mode, the acquire-all control makes all 32 channels acquire together.
// - One active-low pin is chip select in parallel mode and frame sync in serial mode.
// - The offset-select input steers a parallel access to the offset channel.
// - Readback bits leave on the rising shift-clock edge, valid at the next falling edge.
// - The strap picks parallel when low and serial when high, and reads low when undriven.
// - Busy stays low for the whole acquisition and returns high when it ends.
// - With track/reset high, an addressed channel acquires at once.
// - With track/reset low, the input is routed to the addressed channel and acquired on the rise.
// - A low pulse of 90 ns to 200 ns on track/reset returns the device to its power-on state.
// - An undriven track/reset input reads as high.
module dhic_host_ctrl #(
   parameter int ACQ_CYCLES = dhic_pkg::ACQ_CYC_DEFAULT
) (
   input  wire logic                  i_clk,
   input  wire logic                  i_reset,
   input  wire logic                  i_sclk,
   input  wire logic                  i_din,
   input  wire dhic_pkg::dhic_pins_t  i_pins,
   input  wire logic [4:0]            i_addr_float,
   input  wire logic                  i_trk_float,
   input  wire logic                  i_pick_float,
   input  wire logic [13:0]           i_acq_code,
   output logic                       o_busy_n,
   output logic                       o_dout,
   output logic                       o_route_en,
   output logic [5:0]                 o_route_ch,
   output logic [32:0]                o_acq_mask,
   output dhic_pkg::dhic_bank_t       o_chan_code
);

   localparam int ACQ_BOUND = 64;

   typedef struct packed {
      dhic_pkg::dhic_pins_t           m1;
      dhic_pkg::dhic_pins_t           m2;
      logic                           tg1;
      logic                           tg2;
      logic                           tg3;
      logic                           acc_prev;
      logic                           cal_prev;
      logic                           trk_prev;
      logic [3:0]                     low_cnt;
      dhic_pkg::dhic_state_t          st;
      logic [5:0]                     ch;
      logic                           all;
      logic [15:0]                    acq_cnt;
      logic                           busy_n;
      logic                           route_en;
      logic [32:0]                    mask;
      logic [13:0]                    rb;
      dhic_pkg::dhic_bank_t           bank;
   } dhic_sys_t;

   dhic_sys_t             s_r;
   dhic_sys_t             s_nxt;
   dhic_pkg::dhic_pins_t  pins_eff;
   dhic_pkg::dhic_frame_t link_frame;
   logic                  link_tog;
   logic                  link_dout;
   logic                  par;
   logic                  access;
   logic                  acc_rise;
   logic                  cal_rise;
   logic                  frm_ev;
   logic                  trk_rise;
   logic                  rst_pulse;
   logic                  long_low;
   logic                  req;
   logic                  req_all;
   logic [5:0]            req_ch;
   logic [5:0]            frm_ch;

   // Pull-ups and pull-down applied to the pins before synchronising.
   always_comb begin
      pins_eff      = i_pins;
      pins_eff.addr = i_pins.addr | i_addr_float;
      pins_eff.trk  = i_pins.trk | i_trk_float;
      pins_eff.pick = i_pins.pick & ~i_pick_float;
   end

   dhic_serial_link u_link (
      .i_reset     (i_reset),
      .i_sclk      (i_sclk),
      .i_sync_n    (i_pins.cs_n),
      .i_din       (i_din),
      .i_rb_code   (s_r.rb),
      .o_dout      (link_dout),
      .o_frame     (link_frame),
      .o_frame_tog (link_tog)
   );

   always_comb begin
      s_nxt     = s_r;
      s_nxt.m1  = pins_eff;
      s_nxt.m2  = s_r.m1;
      s_nxt.tg1 = link_tog;
      s_nxt.tg2 = s_r.tg1;
      s_nxt.tg3 = s_r.tg2;

      par      = ~s_r.m2.pick;
      access   = ~s_r.m2.cs_n & ~s_r.m2.wr_n;
      acc_rise = par & access & ~s_r.acc_prev;
      cal_rise = par & s_r.m2.cal & ~s_r.cal_prev;
      frm_ev   = ~par & (s_r.tg2 != s_r.tg3);
      trk_rise = s_r.m2.trk & ~s_r.trk_prev;
      s_nxt.acc_prev = access;
      s_nxt.cal_prev = s_r.m2.cal;
      s_nxt.trk_prev = s_r.m2.trk;

      // Low intervals on track/reset are timed to tell a reset from a track.
      if (!s_r.m2.trk) begin
         s_nxt.low_cnt = (s_r.low_cnt == dhic_pkg::TRK_CNT_SAT) ? s_r.low_cnt : s_r.low_cnt + 4'h1;
      end else begin
         s_nxt.low_cnt = 4'h0;
      end
      rst_pulse = trk_rise && (s_r.low_cnt >= dhic_pkg::TRK_MIN_CYC)
                           && (s_r.low_cnt <= dhic_pkg::TRK_MAX_CYC);
      long_low  = trk_rise && (s_r.low_cnt > dhic_pkg::TRK_MAX_CYC);

      req     = 1'b0;
      req_all = 1'b0;
      req_ch  = 6'h00;
      frm_ch  = link_frame.offs ? dhic_pkg::OFFSET_CHAN : {1'b0, link_frame.addr};
      if (acc_rise) begin
         req    = 1'b1;
         req_ch = s_r.m2.offs ? dhic_pkg::OFFSET_CHAN : {1'b0, s_r.m2.addr};
      end else if (cal_rise) begin
         req     = 1'b1;
         req_all = 1'b1;
      end else if (frm_ev) begin
         if (link_frame.rd) begin
            s_nxt.rb = s_r.bank[frm_ch];
         end else if (s_r.m2.hold) begin
            req    = 1'b1;
            req_ch = frm_ch;
         end else begin
            s_nxt.bank[frm_ch] = link_frame.code;
         end
      end

      case (s_r.st)
         dhic_pkg::DHIC_IDLE: begin
            if (req) begin
               s_nxt.ch   = req_ch;
               s_nxt.all  = req_all;
               s_nxt.mask = req_all ? dhic_pkg::MASK_ALL_OUT : (dhic_pkg::MASK_ONE << req_ch);
               if (s_r.m2.trk) begin
                  s_nxt.st      = dhic_pkg::DHIC_ACQ;
                  s_nxt.busy_n  = 1'b0;
                  s_nxt.acq_cnt = 16'(ACQ_CYCLES - 1);
               end else begin
                  s_nxt.st       = dhic_pkg::DHIC_TRACK;
                  s_nxt.route_en = 1'b1;
               end
            end
         end
         dhic_pkg::DHIC_TRACK: begin
            if (long_low) begin
               s_nxt.st       = dhic_pkg::DHIC_ACQ;
               s_nxt.route_en = 1'b0;
               s_nxt.busy_n   = 1'b0;
               s_nxt.acq_cnt  = 16'(ACQ_CYCLES - 1);
            end
         end
         dhic_pkg::DHIC_ACQ: begin
            if (s_r.acq_cnt == 16'h0000) begin
               for (int i = 0; i < 33; i++) begin
                  if (s_r.mask[i]) begin
                     s_nxt.bank[i] = i_acq_code;
                  end
               end
               s_nxt.st     = dhic_pkg::DHIC_IDLE;
               s_nxt.busy_n = 1'b1;
               s_nxt.mask   = '0;
            end else begin
               s_nxt.acq_cnt = s_r.acq_cnt - 16'h0001;
            end
         end
         default: begin
            s_nxt.st = dhic_pkg::DHIC_IDLE;
         end
      endcase

      // A reset pulse returns every control and channel to its power-on value.
      if (rst_pulse) begin
         s_nxt.st       = dhic_pkg::DHIC_IDLE;
         s_nxt.bank     = '0;
         s_nxt.rb       = '0;
         s_nxt.mask     = '0;
         s_nxt.ch       = '0;
         s_nxt.all      = 1'b0;
         s_nxt.acq_cnt  = '0;
         s_nxt.busy_n   = 1'b1;
         s_nxt.route_en = 1'b0;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         s_r          <= '0;
         s_r.m1       <= dhic_pkg::PINS_IDLE;
         s_r.m2       <= dhic_pkg::PINS_IDLE;
         s_r.trk_prev <= 1'b1;
         s_r.busy_n   <= 1'b1;
         s_r.st       <= dhic_pkg::DHIC_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_busy_n    = s_r.busy_n;
   assign o_dout      = link_dout;
   assign o_route_en  = s_r.route_en;
   assign o_route_ch  = s_r.ch;
   assign o_acq_mask  = s_r.mask;
   assign o_chan_code = s_r.bank;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);

   chk_busy_during_acq: assert property (s_r.st == dhic_pkg::DHIC_ACQ |-> !o_busy_n)
      else $error("Busy high during acquisition.");

   chk_busy_release: assert property ($fell(o_busy_n) |-> ##[1:ACQ_BOUND] o_busy_n)
      else $error("Busy never returned high.");

   chk_acquire_all: assert property (s_r.st == dhic_pkg::DHIC_IDLE && cal_rise && !acc_rise
      && !rst_pulse |=> o_acq_mask == dhic_pkg::MASK_ALL_OUT)
      else $error("Acquire-all did not select every channel.");

   chk_addr_decode: assert property (s_r.st == dhic_pkg::DHIC_IDLE && acc_rise && !s_r.m2.offs
      && !rst_pulse |=> o_acq_mask == (dhic_pkg::MASK_ONE << $past(s_r.m2.addr)))
      else $error("Address decode wrong.");

   chk_offset_target: assert property (s_r.st == dhic_pkg::DHIC_IDLE && acc_rise && s_r.m2.offs
      && !rst_pulse |=> o_acq_mask[32] && o_acq_mask[31:0] == 32'h00000000)
      else $error("Offset channel not targeted.");

   chk_track_high_acq: assert property (s_r.st == dhic_pkg::DHIC_IDLE && acc_rise && s_r.m2.trk
      && !rst_pulse |=> s_r.st == dhic_pkg::DHIC_ACQ && !o_busy_n)
      else $error("Addressed channel did not acquire.");

   chk_track_route: assert property (s_r.st == dhic_pkg::DHIC_TRACK |-> o_route_en && o_busy_n)
      else $error("Tracking channel not routed.");

   chk_reset_pulse: assert property (rst_pulse |=> o_chan_code == '0 && o_busy_n && !o_route_en)
      else $error("Reset pulse did not clear the device.");

   chk_long_low: assert property (long_low && s_r.st == dhic_pkg::DHIC_TRACK
      |=> s_r.st == dhic_pkg::DHIC_ACQ && o_chan_code == $past(o_chan_code))
      else $error("Long low treated as reset.");

   chk_cs_idle: assert property (s_r.m2.cs_n && par && !cal_rise && !rst_pulse
      && s_r.st == dhic_pkg::DHIC_IDLE |=> $stable(o_chan_code))
      else $error("Channel changed with select high.");

   chk_busy_idle: assert property (s_r.st == dhic_pkg::DHIC_IDLE
      |-> o_busy_n)
      else $error("Busy low while idle.");

   chk_mask_idle: assert property (s_r.st == dhic_pkg::DHIC_IDLE
      |-> o_acq_mask == 33'h000000000)
      else $error("Channel mask left set while idle.");

   chk_route_track: assert property (o_route_en
      |-> s_r.st == dhic_pkg::DHIC_TRACK)
      else $error("Input routed outside tracking.");

   chk_acq_count: assert property (s_r.st == dhic_pkg::DHIC_ACQ && s_r.acq_cnt != 16'h0000 && !rst_pulse
      |=> s_r.st == dhic_pkg::DHIC_ACQ && s_r.acq_cnt == $past(s_r.acq_cnt) - 16'h0001)
      else $error("Acquisition counter skipped.");

   chk_addr_pullup: assert property ((&i_addr_float) ##1 (&i_addr_float)
      |=> s_r.m2.addr == 5'h1F)
      else $error("Undriven address line not read as one.");

   chk_trk_pullup: assert property (i_trk_float ##1 i_trk_float
      |=> s_r.m2.trk)
      else $error("Undriven track input not read as high.");

   chk_pick_pulldown: assert property (i_pick_float ##1 i_pick_float
      |=> !s_r.m2.pick)
      else $error("Undriven strap not read as low.");

   chk_frame_store: assert property (s_r.st == dhic_pkg::DHIC_IDLE && frm_ev && !link_frame.rd
      && !s_r.m2.hold && !rst_pulse |=> o_chan_code[$past(frm_ch)] == $past(link_frame.code))
      else $error("Serial write not stored.");

   chk_rb_load: assert property (frm_ev && link_frame.rd && !rst_pulse
      |=> s_r.rb == $past(s_r.bank[frm_ch]))
      else $error("Readback register not loaded.");

   chk_rb_par: assert property (par && !rst_pulse
      |=> $stable(s_r.rb))
      else $error("Readback changed in parallel mode.");

endmodule

// ---- tb/dhic_host_model.sv ----
`timescale 1ns/1ps
module dhic_host_model (
   output logic        o_sclk,
   output logic        o_cs_n,
   output logic        o_din,
   input  wire logic   i_dout
);
   // A 75 ns shift clock stays under the converter-mode limit.
   localparam real HALF = 37.5;

   logic [13:0] rb;

   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_din  = 1'b1;
      rb     = '0;
   end

   // Sends one frame first bit first and keeps the first 14 readback bits.
   task automatic send(input dhic_pkg::dhic_frame_t w);
      rb = '0;
      o_cs_n = 1'b0;
      #(HALF);
      for (int b = 20; b >= 0; b--) begin
         o_sclk = 1'b1;
         #(HALF / 2.0);
         o_din = w[b];
         #(HALF / 2.0);
         o_sclk = 1'b0;
         if (b > 6) rb = {rb[12:0], i_dout};
         #(HALF);
      end
      o_cs_n = 1'b1;
      o_din  = 1'b1;
   endtask
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   localparam int ACQ = 4;

   logic                 clk, reset, busy_n, dout, route_en, sclk, host_cs_n, din, pick_float, trk_float;
   logic [4:0]           addr_float;
   logic [13:0]          acq_code;
   logic [5:0]           route_ch;
   logic [32:0]          acq_mask;
   dhic_pkg::dhic_bank_t chan_code;
   dhic_pkg::dhic_pins_t pins, dut_pins;
   int                   n_mismatch, n_checks, n;
   logic [4:0]           a;
   logic [13:0]          c;

   always_comb begin
      dut_pins = pins;
      if (pins.pick && !pick_float) dut_pins.cs_n = host_cs_n;
   end

   dhic_host_ctrl #(.ACQ_CYCLES(ACQ)) i_dut (.i_clk(clk), .i_reset(reset), .i_sclk(sclk), .i_din(din),
      .i_pins(dut_pins), .i_addr_float(addr_float), .i_trk_float(trk_float), .i_pick_float(pick_float),
      .i_acq_code(acq_code), .o_busy_n(busy_n), .o_dout(dout), .o_route_en(route_en), .o_route_ch(route_ch),
      .o_acq_mask(acq_mask), .o_chan_code(chan_code));

   dhic_host_model i_host (.o_sclk(sclk), .o_cs_n(host_cs_n), .o_din(din), .i_dout(dout));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Waits for busy (sel 0) or routing (sel 1) to reach a level, counting cycles.
   task automatic wait_sig(input bit sel, input logic lvl, input int lim, output int cnt);
      cnt = 0;
      while ((sel ? route_en : busy_n) !== lvl && cnt < lim) begin
         @(negedge clk);
         cnt++;
      end
      if ((sel ? route_en : busy_n) !== lvl) begin
         n_mismatch++;
         $display("mismatch wait expected %0d seen timeout", lvl);
         close_out();
      end
   endtask

   task automatic par(input logic [4:0] ad, input logic off, input logic [5:0] ch);
      logic [13:0] code;
      int          k;
      code = 14'($urandom);
      @(negedge clk);
      acq_code = code;
      pins.addr = ad;
      pins.offs = off;
      pins.cs_n = 1'b0;
      pins.wr_n = 1'b0;
      wait_sig(1'b0, 1'b0, 8, k);
      check("mask", 64'(acq_mask), 64'(dhic_pkg::MASK_ONE << ch));
      pins.cs_n = 1'b1;
      pins.wr_n = 1'b1;
      wait_sig(1'b0, 1'b1, ACQ + 8, k);
      check("busy_len", 64'(k), 64'(ACQ));
      check("code", 64'(chan_code[ch]), 64'(code));
      check("mask_clr", 64'(acq_mask), 64'h0);
      repeat (3) @(negedge clk);
   endtask

   initial begin
      reset = 1'b1;
      pins = dhic_pkg::PINS_IDLE;
      addr_float = '0;
      trk_float = 1'b0;
      pick_float = 1'b0;
      acq_code = '0;
      n_mismatch = 0;
      n_checks = 0;
      void'($urandom(64));
      repeat (3) @(negedge clk);
      reset = 1'b0;
      repeat (3) @(negedge clk);
      check("rst_busy", 64'(busy_n), 64'h1);
      repeat (6) begin
         a = 5'($urandom);
         par(a, 1'b0, {1'b0, a});
      end
      par(5'h00, 1'b0, 6'h00);
      par(5'h1F, 1'b0, 6'h1F);
      par(5'($urandom), 1'b1, dhic_pkg::OFFSET_CHAN);
      addr_float = 5'h1F;
      par(5'h00, 1'b0, 6'h1F);
      addr_float = 5'h00;
      pins.wr_n = 1'b0;
      repeat (10) @(negedge clk);
      check("cs_high_busy", 64'(busy_n), 64'h1);
      check("cs_high_mask", 64'(acq_mask), 64'h0);
      pins.wr_n = 1'b1;
      c = 14'($urandom);
      acq_code = c;
      pins.cal = 1'b1;
      wait_sig(1'b0, 1'b0, 8, n);
      check("cal_mask", 64'(acq_mask), 64'(dhic_pkg::MASK_ALL_OUT));
      pins.cal = 1'b0;
      wait_sig(1'b0, 1'b1, ACQ + 8, n);
      check("cal_ch0", 64'(chan_code[0]), 64'(c));
      check("cal_ch31", 64'(chan_code[31]), 64'(c));
      a = 5'($urandom);
      c = 14'($urandom);
      acq_code = c;
      pins.trk = 1'b0;
      repeat (5) @(negedge clk);
      pins.addr = a;
      pins.cs_n = 1'b0;
      pins.wr_n = 1'b0;
      wait_sig(1'b1, 1'b1, 8, n);
      check("route_ch", 64'(route_ch), 64'({1'b0, a}));
      check("route_busy", 64'(busy_n), 64'h1);
      pins.cs_n = 1'b1;
      pins.wr_n = 1'b1;
      repeat (3) @(negedge clk);
      pins.trk = 1'b1;
      wait_sig(1'b0, 1'b0, 8, n);
      wait_sig(1'b0, 1'b1, ACQ + 8, n);
      check("track_code", 64'(chan_code[a]), 64'(c));
      pins.trk = 1'b0;
      trk_float = 1'b1;
      repeat (6) @(negedge clk);
      par(5'h05, 1'b0, 6'h05);
      pins.trk = 1'b1;
      trk_float = 1'b0;
      pick_float = 1'b1;
      pins.pick = 1'b1;
      par(5'h0A, 1'b0, 6'h0A);
      pick_float = 1'b0;
      repeat (4) @(negedge clk);
      a = 5'($urandom);
      c = 14'($urandom);
      i_host.send('{rd: 1'b0, offs: 1'b0, addr: a, code: c});
      repeat (10) @(negedge clk);
      check("ser_write", 64'(chan_code[a]), 64'(c));
      i_host.send('{rd: 1'b1, offs: 1'b0, addr: a, code: 14'h0000});
      repeat (10) @(negedge clk);
      i_host.send('{rd: 1'b1, offs: 1'b0, addr: a, code: 14'h0000});
      check("readback", 64'(i_host.rb), 64'(c));
      repeat (10) @(negedge clk);
      pins.hold = 1'b1;
      c = 14'($urandom);
      acq_code = c;
      repeat (3) @(negedge clk);
      i_host.send('{rd: 1'b0, offs: 1'b1, addr: a, code: 14'h0000});
      wait_sig(1'b0, 1'b0, 8, n);
      check("ser_hold_mask", 64'(acq_mask), 64'(dhic_pkg::MASK_ONE << dhic_pkg::OFFSET_CHAN));
      wait_sig(1'b0, 1'b1, ACQ + 8, n);
      check("ser_hold_code", 64'(chan_code[32]), 64'(c));
      pins.hold = 1'b0;
      repeat (10) @(negedge clk);
      pins.pick = 1'b0;
      repeat (4) @(negedge clk);
      pins.trk = 1'b0;
      @(negedge clk);
      pins.trk = 1'b1;
      repeat (8) @(negedge clk);
      check("soft_reset", 64'(chan_code === '0), 64'h1);
      check("soft_rst_busy", 64'(busy_n), 64'h1);
      close_out();
   end
endmodule
